// ===== hdl/data_lane_unit.sv
// Byte lane selection and extension for data-space reads and writes
`timescale 1ns/1ps
`include "memory_space_defines.svh"
module data_lane_unit (
  input wire logic [15:0] effective_address,
  input wire logic byte_op,
  input wire logic [15:0] write_data,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_implemented,
  input wire memory_space_pkg::extend_op_e ext_op,
  output logic [15:0] lane_wdata,
  output logic [1:0] lane_strobe,
  output logic [15:0] lane_rdata
);
  import memory_space_pkg::*;
  logic [15:0] raw;
  logic [7:0] lane_byte;
  always_comb begin
    raw = mem_implemented ? mem_rdata : 16'h0000;
    lane_byte = effective_address[0] ? raw[15:8] : raw[7:0];
    if (byte_op) begin
      lane_strobe = effective_address[0] ? 2'b10 : 2'b01;
      lane_wdata = {write_data[7:0], write_data[7:0]};
      case (ext_op)
        ext_sign: lane_rdata = {{8{lane_byte[7]}}, lane_byte};
        ext_zero: lane_rdata = {8'h00, lane_byte};
        default: lane_rdata = {8'h00, lane_byte};
      endcase
    end else begin
      lane_rdata = raw;
      lane_strobe = 2'b11;
      lane_wdata = write_data;
    end
  end
endmodule : data_lane_unit

// ===== hdl/memory_space_access_unit.sv
// Memory space access unit: program and data address decode and access control
// Behaviour
// - Program addresses are 24 bits, from 23-bit counter, table ops or remapping.
// - Ordinary program accesses confined to 0x000000 through 0x7fffff.
// - Table read/write with table page bit 7 reach configuration space.
// - Program location is 24 bits; upper word's top byte unimplemented.
// - Lower word at even address, upper word at next odd address.
// - Program counter stays even and steps by two.
// - Execution starts at 0x000000 after reset; start pointer at 0x000002.
// - Region below 0x000200 is reserved for execution vectors.
// - Primary vector table 0x000004-0x0000ff, alternate 0x000100-0x0001ff.
// - Data effective addresses are 16-bit byte addresses.
// - Address bit 15 low selects data memory, high selects visibility window.
// - Reads outside implemented memory return zero.
// - Low byte at even address, high byte at odd address.
// - Post-increment adds 1 for byte, 2 for word operations.
// - Byte read selects byte by address bit 0 onto low lane.
// - Shared word decode; byte write strobes only the addressed lane.
// - Word access at odd address raises address error trap.
// - Misaligned read completes; misaligned write is suppressed; then trap.
// - Byte load without extension into working register changes only its low byte.
// - Sign-extend and zero-extend operations on byte values.
// - Data addresses 0x0000-0x07ff decode as special function registers.
// - Unused special function register addresses read zero.
// - Upper data half maps to program space via 8-bit visibility page.
`timescale 1ns/1ps
`include "memory_space_defines.svh"
module memory_space_access_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pc_step,
  input wire logic pc_backward,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_value,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [7:0] table_page_pointer,
  input wire logic [15:0] table_offset,
  input wire logic table_upper,
  input wire logic [7:0] visibility_page_register,
  input wire logic visibility_enable,
  input wire logic data_read,
  input wire logic data_write,
  input wire logic byte_op,
  input wire logic [15:0] effective_address,
  input wire logic post_increment,
  input wire logic [15:0] write_data,
  input wire memory_space_pkg::extend_op_e ext_op,
  input wire logic reg_load,
  input wire logic [15:0] reg_old,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_implemented,
  input wire logic [23:0] prog_rdata,
  output logic [23:0] prog_address,
  output logic prog_read,
  output logic prog_upper_word,
  output memory_space_pkg::prog_region_e prog_region,
  output logic prog_in_vector_table,
  output logic [15:0] mem_address,
  output logic mem_read,
  output logic [1:0] mem_write_strobe,
  output logic [15:0] mem_wdata,
  output logic sfr_select,
  output logic psv_select,
  output logic [15:0] read_data,
  output logic [15:0] reg_new,
  output logic [15:0] next_pointer,
  output logic address_error_trap
);
  import memory_space_pkg::*;

  typedef struct packed {
    logic [22:0] pc;
    logic [23:0] prog_address;
    logic prog_read;
    logic prog_upper_word;
    prog_region_e prog_region;
    logic prog_in_vector_table;
    logic [15:0] mem_address;
    logic mem_read;
    logic [1:0] mem_write_strobe;
    logic [15:0] mem_wdata;
    logic sfr_select;
    logic psv_select;
    logic [15:0] read_data;
    logic [15:0] reg_new;
    logic [15:0] next_pointer;
    logic address_error_trap;
  } state_s;

  state_s state_q;
  state_s state_d;

  prog_region_e region_w;
  logic alt_hit_w;
  logic pri_hit_w;
  logic [15:0] lane_wdata_w;
  logic [1:0] lane_strobe_w;
  logic [15:0] lane_rdata_w;
  logic [15:0] sel_rdata_w;
  logic implemented_w;
  logic table_op_w;
  logic [23:0] fetch_addr_w;

  // Pointer step depends on operand size
  function automatic logic [15:0] scaled_step(input logic is_byte);
    scaled_step = is_byte ? `STEP_BYTE : `STEP_WORD;
  endfunction : scaled_step

  // Odd address on a word access is misaligned
  function automatic logic misaligned(input logic is_byte, input logic [15:0] ea);
    misaligned = !is_byte && ea[0];
  endfunction : misaligned

  // Program word view of a 24-bit location: even lower word, odd upper byte
  function automatic logic [15:0] prog_word(input logic [23:0] loc, input logic upper);
    prog_word = upper ? {8'h00, loc[23:16]} : loc[15:0];
  endfunction : prog_word

  assign table_op_w = table_read_op || table_write_op;

  always_comb begin
    fetch_addr_w = {1'b0, state_q.pc};
    if (table_op_w) begin
      fetch_addr_w = {table_page_pointer, table_offset[15:1], 1'b0};
    end else if (data_read && effective_address[`DATA_PSV_BIT] && visibility_enable) begin
      fetch_addr_w = {1'b0, visibility_page_register, effective_address[14:1], 1'b0};
    end
  end

  prog_decode_unit u_prog_decode (
    .prog_address(fetch_addr_w),
    .table_op(table_op_w),
    .table_page_pointer(table_page_pointer),
    .region(region_w),
    .alt_table_hit(alt_hit_w),
    .pri_table_hit(pri_hit_w)
  );

  assign implemented_w = !effective_address[`DATA_PSV_BIT] && effective_address < `DATA_MEM_LIMIT && mem_implemented;
  assign sel_rdata_w = effective_address[`DATA_PSV_BIT] ?
    (visibility_enable ? prog_word(prog_rdata, 1'b0) : 16'h0000) : mem_rdata;

  data_lane_unit u_data_lane (
    .effective_address(effective_address),
    .byte_op(byte_op),
    .write_data(write_data),
    .mem_rdata(sel_rdata_w),
    .mem_implemented(implemented_w || (effective_address[`DATA_PSV_BIT] && visibility_enable)),
    .ext_op(ext_op),
    .lane_wdata(lane_wdata_w),
    .lane_strobe(lane_strobe_w),
    .lane_rdata(lane_rdata_w)
  );

  always_comb begin
    state_d = state_q;
    state_d.mem_read = 1'b0;
    state_d.mem_write_strobe = 2'b00;
    state_d.prog_read = 1'b0;
    state_d.address_error_trap = 1'b0;
    if (pc_load) begin
      state_d.pc = {pc_load_value[22:1], 1'b0};
    end else if (pc_step) begin
      state_d.pc = pc_backward ? state_q.pc - `PROG_PC_STEP : state_q.pc + `PROG_PC_STEP;
    end
    state_d.prog_address = fetch_addr_w;
    state_d.prog_region = region_w;
    state_d.prog_in_vector_table = pri_hit_w || alt_hit_w;
    state_d.prog_upper_word = table_op_w && table_upper;
    state_d.prog_read = (table_read_op || !table_op_w) && region_w != region_blocked;
    state_d.mem_address = {effective_address[15:1], 1'b0};
    state_d.sfr_select = effective_address <= `SFR_LAST;
    state_d.psv_select = effective_address[`DATA_PSV_BIT];
    state_d.mem_wdata = lane_wdata_w;
    if (data_read || data_write) begin
      state_d.address_error_trap = misaligned(byte_op, effective_address);
    end
    if (data_read) begin
      state_d.mem_read = !effective_address[`DATA_PSV_BIT];
      state_d.read_data = lane_rdata_w;
      state_d.reg_new = (reg_load && byte_op && ext_op == ext_none) ?
        {reg_old[15:8], lane_rdata_w[7:0]} : lane_rdata_w;
    end
    if (data_write && !misaligned(byte_op, effective_address) && !effective_address[`DATA_PSV_BIT]) begin
      state_d.mem_write_strobe = lane_strobe_w;
    end
    if ((data_read || data_write) && post_increment) begin
      state_d.next_pointer = effective_address + scaled_step(byte_op);
    end
    if (!resetn) begin
      state_d = '0;
      state_d.pc = 23'(`PROG_RESET_ADDR);
      state_d.prog_region = region_vector;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign prog_address = state_q.prog_address;
  assign prog_read = state_q.prog_read;
  assign prog_upper_word = state_q.prog_upper_word;
  assign prog_region = state_q.prog_region;
  assign prog_in_vector_table = state_q.prog_in_vector_table;
  assign mem_address = state_q.mem_address;
  assign mem_read = state_q.mem_read;
  assign mem_write_strobe = state_q.mem_write_strobe;
  assign mem_wdata = state_q.mem_wdata;
  assign sfr_select = state_q.sfr_select;
  assign psv_select = state_q.psv_select;
  assign read_data = state_q.read_data;
  assign reg_new = state_q.reg_new;
  assign next_pointer = state_q.next_pointer;
  assign address_error_trap = state_q.address_error_trap;
endmodule : memory_space_access_unit

// ===== hdl/memory_space_defines.svh
// Address map constants for the memory space access unit
`ifndef MEMORY_SPACE_DEFINES_SVH
`define MEMORY_SPACE_DEFINES_SVH
`define PROG_USER_MAX 24'h7fffff
`define PROG_RESET_ADDR 24'h000000
`define PROG_START_PTR_ADDR 24'h000002
`define PROG_VEC_END 24'h000200
`define PROG_IVT_LO 24'h000004
`define PROG_IVT_HI 24'h0000ff
`define PROG_AIVT_LO 24'h000100
`define PROG_AIVT_HI 24'h0001ff
`define PROG_PC_STEP 23'h000002
`define TBL_PAGE_CFG_BIT 7
`define DATA_PSV_BIT 15
`define DATA_MEM_LIMIT 16'h7800
`define SFR_LAST 16'h07ff
`define PSV_PAGE_SHIFT 15
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
`endif

// ===== hdl/memory_space_pkg.sv
// Types shared by the memory space access unit
package memory_space_pkg;
  typedef enum logic [1:0] {
    region_vector,
    region_code,
    region_config,
    region_blocked
  } prog_region_e;
  typedef enum logic [1:0] {
    ext_none,
    ext_sign,
    ext_zero
  } extend_op_e;
endpackage : memory_space_pkg

// ===== hdl/prog_decode_unit.sv
// Program space region decode and user-limit check
`timescale 1ns/1ps
`include "memory_space_defines.svh"
module prog_decode_unit (
  input wire logic [23:0] prog_address,
  input wire logic table_op,
  input wire logic [7:0] table_page_pointer,
  output memory_space_pkg::prog_region_e region,
  output logic alt_table_hit,
  output logic pri_table_hit
);
  import memory_space_pkg::*;
  always_comb begin
    pri_table_hit = (prog_address >= `PROG_IVT_LO) && (prog_address <= `PROG_IVT_HI);
    alt_table_hit = (prog_address >= `PROG_AIVT_LO) && (prog_address <= `PROG_AIVT_HI);
    if (prog_address > `PROG_USER_MAX) begin
      region = (table_op && table_page_pointer[`TBL_PAGE_CFG_BIT]) ? region_config : region_blocked;
    end else if (prog_address < `PROG_VEC_END) begin
      region = region_vector;
    end else begin
      region = region_code;
    end
  end
endmodule : prog_decode_unit

// ===== testbench/core_memory_model.sv
// Data memory and program store that answer the access unit
`timescale 1ns/1ps
module core_memory_model (
  input wire logic [15:0] addr,
  output logic [15:0] mem_rdata,
  output logic mem_implemented,
  output logic [23:0] prog_rdata
);
  always_comb begin
    // A hole at 0x0700-0x07ff stands for unused register space
    mem_implemented = addr < 16'h7800 && addr[15:8] != 8'h07;
    // Data keeps driving a pattern when unimplemented, so zeroing is the unit's job
    mem_rdata = {addr[15:1], 1'b0} ^ 16'h5a3c;
    prog_rdata = {8'ha5, ~addr};
  end
endmodule : core_memory_model

// ===== testbench/memory_space_access_unit_asserts.sv
// Port-level checks of the memory space access unit
`timescale 1ns/1ps
module memory_space_access_unit_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic data_read,
  input wire logic data_write,
  input wire logic byte_op,
  input wire logic [15:0] effective_address,
  input wire logic post_increment,
  input wire logic visibility_enable,
  input wire logic table_read_op,
  input wire logic [7:0] table_page_pointer,
  input wire logic mem_read,
  input wire logic [15:0] mem_address,
  input wire logic [1:0] mem_write_strobe,
  input wire logic sfr_select,
  input wire logic psv_select,
  input wire logic [15:0] next_pointer,
  input wire logic address_error_trap,
  input wire logic [23:0] prog_address,
  input wire memory_space_pkg::prog_region_e prog_region
);
  import memory_space_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  misalign_trap_a: assert property ((data_read || data_write) |=> address_error_trap ==
    $past(!byte_op && effective_address[0])) else $error("trap does not match alignment");
  write_block_a: assert property (data_write && !byte_op && effective_address[0] |=>
    mem_write_strobe == 2'b00) else $error("misaligned write strobed");
  byte_lane_a: assert property (data_write && byte_op && !effective_address[15] |=>
    mem_write_strobe == ($past(effective_address[0]) ? 2'b10 : 2'b01)) else $error("wrong byte lane");
  word_address_a: assert property (data_read && !effective_address[15] |=> mem_read &&
    mem_address == {$past(effective_address[15:1]), 1'b0}) else $error("bad memory read address");
  step_scale_a: assert property ((data_read || data_write) && post_increment |=> next_pointer ==
    $past(effective_address) + ($past(byte_op) ? 16'h0001 : 16'h0002)) else $error("bad pointer step");
  sfr_decode_a: assert property (data_read && !effective_address[15] |=>
    sfr_select == ($past(effective_address) <= 16'h07ff)) else $error("bad register decode");
  psv_route_a: assert property (data_read && visibility_enable |=>
    psv_select == $past(effective_address[15])) else $error("bad window select");
  reset_start_a: assert property ($rose(resetn) |-> prog_address == 24'h000000)
    else $error("start address not zero");
  cfg_region_a: assert property (table_read_op && table_page_pointer[7] |=>
    prog_region == region_config) else $error("configuration region not reached");
  cover property (data_write && !byte_op && effective_address[0]);
  cover property (data_write && byte_op && !effective_address[15]);
  cover property (data_read && effective_address[15] && visibility_enable);
endmodule : memory_space_access_unit_asserts
bind memory_space_access_unit memory_space_access_unit_asserts i_chk (.clk, .resetn, .data_read, .data_write,
  .byte_op, .effective_address, .post_increment, .visibility_enable, .table_read_op, .table_page_pointer,
  .mem_read, .mem_address, .mem_write_strobe, .sfr_select, .psv_select, .next_pointer, .address_error_trap,
  .prog_address, .prog_region);

// ===== testbench/test_memory_space_access_unit.sv
// Self-checking bench of the memory space access unit
`timescale 1ns/1ps
module test_memory_space_access_unit;
  import memory_space_pkg::*;
  logic clk = 0, resetn = 0, pc_step = 0, pc_backward = 0, pc_load = 0, table_read_op = 0, table_write_op = 0;
  logic table_upper = 0, visibility_enable = 0, data_read = 0, data_write = 0, byte_op = 0, post_increment = 0;
  logic reg_load = 0, mem_implemented, prog_read, prog_upper_word, prog_in_vector_table, mem_read;
  logic sfr_select, psv_select, address_error_trap, rd;
  logic [22:0] pc_load_value = 0, v;
  logic [7:0] table_page_pointer = 0, visibility_page_register = 0, b;
  logic [15:0] table_offset = 0, effective_address = 0, write_data = 0, reg_old = 0, mem_rdata, mem_address;
  logic [15:0] mem_wdata, read_data, reg_new, next_pointer, ea, w;
  logic [23:0] prog_rdata, prog_address, a;
  logic [1:0] mem_write_strobe;
  extend_op_e ext_op = ext_none;
  prog_region_e prog_region;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  memory_space_access_unit i_dut (.clk, .resetn, .pc_step, .pc_backward, .pc_load, .pc_load_value,
    .table_read_op, .table_write_op, .table_page_pointer, .table_offset, .table_upper, .visibility_page_register,
    .visibility_enable, .data_read, .data_write, .byte_op, .effective_address, .post_increment, .write_data,
    .ext_op, .reg_load, .reg_old, .mem_rdata, .mem_implemented, .prog_rdata, .prog_address, .prog_read,
    .prog_upper_word, .prog_region, .prog_in_vector_table, .mem_address, .mem_read, .mem_write_strobe,
    .mem_wdata, .sfr_select, .psv_select, .read_data, .reg_new, .next_pointer, .address_error_trap);
  core_memory_model i_mem (.addr(effective_address), .mem_rdata, .mem_implemented, .prog_rdata);
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up;
    end
  end
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input bit ok);
    cmp_count++;
    if (!ok) begin
      $display("unexpected at %0t: output differs from model", $time);
      miscompares++;
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'hec7b7ad7));
    repeat (5) tick;
    resetn = 1;
    chk(prog_address === 24'h000000 && prog_region === region_vector);
    v = {3'b000, 20'($urandom)};
    pc_load = 1;
    pc_load_value = v;
    tick;
    pc_load = 0;
    // The fetch address follows the counter register one cycle later
    tick;
    chk(prog_address === {1'b0, v[22:1], 1'b0});
    pc_step = 1;
    repeat (3) tick;
    pc_step = 0;
    tick;
    chk(prog_address === {1'b0, v[22:1], 1'b0} + 24'h000006);
    pc_step = 1;
    pc_backward = 1;
    repeat (2) tick;
    pc_step = 0;
    pc_backward = 0;
    tick;
    chk(prog_address === {1'b0, v[22:1], 1'b0} + 24'h000002);
    for (int i = 0; i < 8; i++) begin
      table_read_op = i[0];
      table_write_op = !i[0];
      table_page_pointer = {i[1], 7'($urandom)} & (i[2] ? 8'h80 : 8'hff);
      table_offset = i[2] ? 16'($urandom) & 16'h01ff : 16'($urandom);
      table_upper = 1'($urandom);
      tick;
      a = {table_page_pointer, table_offset[15:1], 1'b0};
      chk(prog_address === a && prog_upper_word === table_upper);
      chk(prog_region === (i[1] ? region_config : a < 24'h000200 ? region_vector : region_code));
      chk(prog_in_vector_table === (a >= 24'h000004 && a <= 24'h0001ff));
      chk(prog_read === i[0]);
    end
    table_read_op = 0;
    table_write_op = 0;
    for (int i = 0; i < 60; i++) begin
      ea = 16'($urandom) >> (i % 4 * 4);
      rd = 1'($urandom);
      {effective_address, data_read, data_write, byte_op, post_increment, reg_load} = {ea, rd, !rd, 1'($urandom), 2'b11};
      {write_data, reg_old, visibility_page_register} = {16'($urandom), 16'($urandom), 8'($urandom)};
      visibility_enable = $urandom % 4 != 0;
      ext_op = extend_op_e'($urandom % 3);
      tick;
      {data_read, data_write, post_increment, reg_load} = 4'h0;
      w = ea[15] ? (visibility_enable ? ~ea : 16'h0000) : (ea < 16'h7800 && ea[15:8] != 8'h07 ? {ea[15:1], 1'b0} ^ 16'h5a3c : 16'h0000);
      b = ea[0] ? w[15:8] : w[7:0];
      chk(address_error_trap === (!byte_op && ea[0]));
      chk(next_pointer === ea + (byte_op ? 16'h0001 : 16'h0002));
      if (rd) begin
        if (!ea[15]) chk(mem_read === 1'b1 && mem_address === {ea[15:1], 1'b0} && sfr_select === (ea <= 16'h07ff));
        if (visibility_enable) chk(psv_select === ea[15]);
        if (ea[15] && visibility_enable) chk(prog_address === {1'b0, visibility_page_register, ea[14:1], 1'b0});
        if (!byte_op) chk(read_data === w);
        else if (ext_op == ext_none) chk(read_data[7:0] === b && reg_new === {reg_old[15:8], b});
        else chk(read_data === (ext_op == ext_sign ? {{8{b[7]}}, b} : {8'h00, b}));
      end else begin
        chk(mem_write_strobe === (ea[15] || (!byte_op && ea[0]) ? 2'b00 : !byte_op ? 2'b11 : ea[0] ? 2'b10 : 2'b01));
        if (!ea[15] && (byte_op || !ea[0])) chk(mem_wdata === (byte_op ? {2{write_data[7:0]}} : write_data));
      end
      tick;
    end
    wrap_up;
  end
endmodule : test_memory_space_access_unit
